// ===== verilog/efs_cfg.svh
// Purpose: constants of the earth fault pick-up stage (offsets, fields, resets, timing)
// Assumes: 100 MHz clk, byte offsets on a 10-bit register port, current in 0.0001 x In units
// Notes: definitions only
//
// Summary of operation
// RQ1: a static setting picks coarse, sensitive or calculated residual current.
// RQ2: magnitude type applies to measured inputs only; calculated uses fundamental.
// RQ3: measurements are taken on a fixed 5 ms time base.
// RQ4: TRMS input carries the 32-component harmonic magnitude, not fundamental.
// RQ5: pick-up when the selected magnitude exceeds the threshold.
// RQ6: release only below 97 percent of threshold; ratio is fixed.
// RQ7: threshold in 0.0001 x In steps, default 1.20 x In.
// RQ8: active setting group may change while the stage runs.
// RQ9: remote threshold writes need a permission bit, off by default.
// RQ10: force setting overrides condition, only while global forcing is enabled.
// RQ11: condition reads as exactly one of normal, start, trip, blocked.
// RQ12: angle in 0.01 deg, referenced to U1 if voltages exist, else I1.
// RQ13: last fault reads as none or phase A/B/C to ground, forward/reverse.
// RQ14: expected time in 5 ms steps; inverse mode recomputes it from current.
// RQ15: while timing toward trip, remaining time counts down in 5 ms steps.
// RQ16: measured-to-set ratio reported continuously with 0.01 resolution.
// RQ17: selection, magnitude type, force, permission are static, outside groups.
// RQ18: pick-up with block inactive gives start; with block active gives blocked.
// RQ19: the block input must arrive at least 5 ms before the delay expires.
// RQ20: four independent stages, each with start, trip and block outputs.
// RQ21: comparisons run once per measurement update; pick-up held between.
// RQ22: a pick-up released before trip returns the condition to normal.
`ifndef EFS_CFG_SVH
`define EFS_CFG_SVH

`define EFS_STAGES 4
`define EFS_GROUPS 8
`define EFS_GRP_W 3
`define EFS_MEAS_W 20
`define EFS_TIME_W 19
`define EFS_RATIO_W 17
`define EFS_ANG_W 17
`define EFS_ANGD_W 18
`define EFS_ADDR_W 10

`define EFS_THR_DEF 20'h0_2EE0
`define EFS_DLY_DEF 19'h0_0014
`define EFS_RATIO_MAX 17'h1_E848
`define EFS_TIME_MAX 19'h7_FFFF
`define EFS_HYST_PCT 27'h000_0061
`define EFS_FULL_PCT 27'h000_0064

`define EFS_CLK_KHZ 100000
`define EFS_TICK_MS 5
`define EFS_TICK_CYCLES (`EFS_TICK_MS * `EFS_CLK_KHZ)

`define EFS_OFF_CFG 7'h00
`define EFS_OFF_REMOTE_THR 7'h04
`define EFS_OFF_STATUS 7'h08
`define EFS_OFF_ANGLE 7'h0C
`define EFS_OFF_EXPECT 7'h10
`define EFS_OFF_REMAIN 7'h14
`define EFS_OFF_RATIO 7'h18
`define EFS_OFF_MAG 7'h1C
`define EFS_OFF_THR_HI 2'h2
`define EFS_OFF_DLY_HI 2'h3
`define EFS_ADDR_GCTL 10'h200

`define EFS_CFG_SEL_LSB 0
`define EFS_CFG_MAG_LSB 2
`define EFS_CFG_FORCE_LSB 4
`define EFS_CFG_REMOTE_BIT 6
`define EFS_CFG_INV_BIT 7
`define EFS_STAT_FAULT_LSB 4

`endif

// ===== verilog/efs_pkg.sv
// Purpose: types of the earth fault pick-up stage
// Assumes: efs_cfg.svh holds all numbers
// Notes: state structs for the top and the block-input filter
`default_nettype none
`include "efs_cfg.svh"

package efs_pkg;

  typedef enum logic [1:0] {EFS_NORMAL, EFS_START, EFS_TRIP, EFS_BLOCKED} efs_cond_e;
  typedef enum logic [2:0] {EFS_FT_NONE, EFS_FT_AGF, EFS_FT_AGR, EFS_FT_BGF, EFS_FT_BGR,
                            EFS_FT_CGF, EFS_FT_CGR} efs_fault_e;
  typedef enum logic [1:0] {EFS_SRC_COARSE, EFS_SRC_SENSITIVE, EFS_SRC_CALC} efs_src_e;
  typedef enum logic [1:0] {EFS_MAG_RMS, EFS_MAG_TRMS, EFS_MAG_PP} efs_mag_e;

  typedef struct packed {
    efs_src_e sel;
    efs_mag_e magt;
    efs_cond_e force_to;
    logic remote_ok;
    logic inverse;
    logic [`EFS_GROUPS-1:0][`EFS_MEAS_W-1:0] thr;
    logic [`EFS_GROUPS-1:0][`EFS_TIME_W-1:0] dly;
    logic pickup;
    efs_cond_e state;
    efs_cond_e cond;
    efs_fault_e fault;
    logic [`EFS_MEAS_W-1:0] mag;
    logic signed [`EFS_ANGD_W-1:0] angle;
    logic [`EFS_TIME_W-1:0] exp_time;
    logic [`EFS_TIME_W-1:0] elapsed;
    logic [`EFS_TIME_W-1:0] remain;
    logic [`EFS_RATIO_W-1:0] ratio;
  } efs_stage_s;

  typedef struct packed {
    logic [31:0] tick_cnt;
    logic tick;
    logic force_en;
    logic [31:0] rdata;
    efs_stage_s [`EFS_STAGES-1:0] st;
  } efs_top_s;

  typedef struct packed {
    logic [`EFS_STAGES-1:0] s1;
    logic [`EFS_STAGES-1:0] s2;
    logic [`EFS_STAGES-1:0] s3;
    logic [`EFS_STAGES-1:0] filt;
  } efs_sync_s;

endpackage : efs_pkg

`default_nettype wire

// ===== verilog/efs_sync.sv
// Purpose: three-flop synchroniser and agree filter for the external block inputs
// Assumes: block inputs are asynchronous pins
// Notes: a change is accepted once the second and third stage agree
`default_nettype none
`include "efs_cfg.svh"

module efs_sync
  import efs_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // pins and filtered levels
  input wire logic [`EFS_STAGES-1:0] async_in,
  output logic [`EFS_STAGES-1:0] filt
);

  efs_sync_s q;
  efs_sync_s d;

  always_comb begin
    d = q;
    d.s1 = async_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // s1 is only read by s2; the filter looks at s2 and s3
    d.filt = ((q.s2 ~^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.filt);
    if (!ce) begin
      d = q;
    end
    if (sys_rst) begin
      d = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign filt = q.filt;

endmodule : efs_sync

`default_nettype wire

// ===== verilog/efs_top.sv
// Purpose: four non-directional earth fault pick-up stages with a register port
// Assumes: measurement and angle inputs come from logic on clk; block inputs are pins
// Notes: definite delay or a simple inverse curve; event buffer and records live elsewhere
//
// Implementation choices: the strobed register port and the register offsets.
`default_nettype none
`include "efs_cfg.svh"

module efs_top
  import efs_pkg::*;
#(
  parameter int TICK_CYCLES = `EFS_TICK_CYCLES
) (
  // clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // register port
  input wire logic [`EFS_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // residual current measurements
  input wire logic [`EFS_MEAS_W-1:0] coarse_rms,
  input wire logic [`EFS_MEAS_W-1:0] coarse_trms,
  input wire logic [`EFS_MEAS_W-1:0] coarse_pp,
  input wire logic [`EFS_MEAS_W-1:0] sensitive_rms,
  input wire logic [`EFS_MEAS_W-1:0] sensitive_trms,
  input wire logic [`EFS_MEAS_W-1:0] sensitive_pp,
  input wire logic [`EFS_MEAS_W-1:0] calculated_residual,
  // angles and fault classification
  input wire logic signed [`EFS_ANG_W-1:0] residual_angle,
  input wire logic signed [`EFS_ANG_W-1:0] pos_seq_voltage_angle,
  input wire logic signed [`EFS_ANG_W-1:0] pos_seq_current_angle,
  input wire logic phase_voltages_present,
  input wire logic [1:0] fault_phase,
  input wire logic fault_reverse,
  // setting group and blocking
  input wire logic [`EFS_GRP_W-1:0] active_group,
  input wire logic [`EFS_STAGES-1:0] block_in,
  // stage outputs
  output logic [`EFS_STAGES-1:0] stage_start,
  output logic [`EFS_STAGES-1:0] stage_trip,
  output logic [`EFS_STAGES-1:0] stage_blocked
);

  efs_top_s q;
  efs_top_s d;
  logic [`EFS_STAGES-1:0] block_filt;

  efs_sync u_block_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .async_in(block_in),
    .filt(block_filt)
  );

  always_comb begin
    logic [6:0] off;
    logic stage_hit;
    logic [`EFS_MEAS_W-1:0] sample;
    logic [`EFS_MEAS_W-1:0] thr_act;
    logic [`EFS_TIME_W-1:0] dly_act;
    logic pu_next;
    logic [26:0] mag_pct;
    logic [26:0] thr_pct;
    logic [38:0] inv_num;
    logic [38:0] inv_quo;
    logic [26:0] rat_quo;
    logic [`EFS_TIME_W-1:0] el_next;
    logic [`EFS_TIME_W-1:0] exp_next;
    logic [31:0] rd_val;
    efs_fault_e fault_now;
    off = reg_addr[6:0];
    stage_hit = 1'b0;
    sample = '0;
    thr_act = '0;
    dly_act = '0;
    pu_next = 1'b0;
    mag_pct = '0;
    thr_pct = '0;
    inv_num = '0;
    inv_quo = '0;
    rat_quo = '0;
    el_next = '0;
    exp_next = '0;
    rd_val = '0;
    fault_now = efs_fault_e'(3'(1) + 3'({fault_phase, 1'b0}) + 3'(fault_reverse)); // [RQ13]
    d = q;

    // time base for every measurement update
    if (q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin // [RQ3]
      d.tick_cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 32'h0000_0001;
      d.tick = 1'b0;
    end

    // global forcing enable, shared by all stages
    if (reg_wr && reg_addr == `EFS_ADDR_GCTL) begin
      d.force_en = reg_wdata[0];
    end

    for (int i = 0; i < `EFS_STAGES; i++) begin // [RQ20]
      stage_hit = !reg_addr[9] && (reg_addr[8:7] == 2'(i));

      // static settings sit outside the group arrays, so a group change leaves them alone
      if (reg_wr && stage_hit && off == `EFS_OFF_CFG) begin // [RQ17]
        if (reg_wdata[`EFS_CFG_SEL_LSB +: 2] != 2'h3) begin
          d.st[i].sel = efs_src_e'(reg_wdata[`EFS_CFG_SEL_LSB +: 2]); // [RQ1]
        end
        if (reg_wdata[`EFS_CFG_MAG_LSB +: 2] != 2'h3) begin
          d.st[i].magt = efs_mag_e'(reg_wdata[`EFS_CFG_MAG_LSB +: 2]);
        end
        d.st[i].force_to = efs_cond_e'(reg_wdata[`EFS_CFG_FORCE_LSB +: 2]);
        d.st[i].remote_ok = reg_wdata[`EFS_CFG_REMOTE_BIT];
        d.st[i].inverse = reg_wdata[`EFS_CFG_INV_BIT];
      end
      // remote writes land in the active group only when permitted
      if (reg_wr && stage_hit && off == `EFS_OFF_REMOTE_THR && q.st[i].remote_ok) begin // [RQ9]
        d.st[i].thr[active_group] = reg_wdata[`EFS_MEAS_W-1:0]; // [RQ7]
      end
      if (reg_wr && stage_hit && off[6:5] == `EFS_OFF_THR_HI && off[1:0] == 2'h0) begin
        d.st[i].thr[off[4:2]] = reg_wdata[`EFS_MEAS_W-1:0]; // [RQ7]
      end
      if (reg_wr && stage_hit && off[6:5] == `EFS_OFF_DLY_HI && off[1:0] == 2'h0) begin
        d.st[i].dly[off[4:2]] = reg_wdata[`EFS_TIME_W-1:0];
      end

      // group selection is read live each update, no restart needed
      thr_act = q.st[i].thr[active_group]; // [RQ8]
      dly_act = q.st[i].dly[active_group];

      case (q.st[i].sel) // [RQ1]
        EFS_SRC_COARSE: begin
          case (q.st[i].magt) // [RQ2]
            EFS_MAG_TRMS: sample = coarse_trms; // [RQ4]
            EFS_MAG_PP: sample = coarse_pp;
            default: sample = coarse_rms;
          endcase
        end
        EFS_SRC_SENSITIVE: begin
          case (q.st[i].magt) // [RQ2]
            EFS_MAG_TRMS: sample = sensitive_trms; // [RQ4]
            EFS_MAG_PP: sample = sensitive_pp;
            default: sample = sensitive_rms;
          endcase
        end
        default: sample = calculated_residual; // [RQ2]
      endcase

      mag_pct = 27'(sample) * `EFS_FULL_PCT;
      thr_pct = 27'(thr_act) * `EFS_HYST_PCT;
      if (!q.st[i].pickup) begin
        pu_next = sample > thr_act; // [RQ5]
      end else begin
        pu_next = !(mag_pct < thr_pct); // [RQ6]
      end

      // inverse mode scales the delay by threshold over current; zero current saturates, no divide
      inv_num = 39'(dly_act) * 39'(thr_act);
      inv_quo = (sample == '0) ? 39'(`EFS_TIME_MAX) : inv_num / 39'(sample);
      if (!q.st[i].inverse) begin
        exp_next = dly_act;
      end else if (inv_quo > 39'(`EFS_TIME_MAX)) begin
        exp_next = `EFS_TIME_MAX;
      end else begin
        exp_next = inv_quo[`EFS_TIME_W-1:0]; // [RQ14]
      end
      // ratio saturates instead of wrapping when the threshold is tiny
      rat_quo = (thr_act == '0) ? 27'(`EFS_RATIO_MAX) : mag_pct / 27'(thr_act);
      el_next = q.st[i].elapsed + `EFS_TIME_W'(1);

      // all evaluation waits for the update, state is held in between
      if (q.tick) begin // [RQ21]
        d.st[i].mag = sample;
        d.st[i].pickup = pu_next;
        d.st[i].exp_time = exp_next; // [RQ14]
        d.st[i].ratio = (rat_quo > 27'(`EFS_RATIO_MAX)) ? `EFS_RATIO_MAX
                                                        : rat_quo[`EFS_RATIO_W-1:0]; // [RQ16]
        if (phase_voltages_present) begin // [RQ12]
          d.st[i].angle = `EFS_ANGD_W'(residual_angle) - `EFS_ANGD_W'(pos_seq_voltage_angle);
        end else begin
          d.st[i].angle = `EFS_ANGD_W'(residual_angle) - `EFS_ANGD_W'(pos_seq_current_angle);
        end
        // block only matters at pick-up and while timing
        case (q.st[i].state)
          EFS_NORMAL: begin
            if (pu_next && block_filt[i]) begin
              d.st[i].state = EFS_BLOCKED; // [RQ18]
            end else if (pu_next) begin
              d.st[i].state = EFS_START; // [RQ18]
              d.st[i].elapsed = '0;
              d.st[i].fault = fault_now; // [RQ13]
            end
          end
          EFS_START: begin
            if (!pu_next) begin
              d.st[i].state = EFS_NORMAL; // [RQ22]
              d.st[i].elapsed = '0;
            end else if (block_filt[i]) begin
              // block seen during timing drops the start
              d.st[i].state = EFS_BLOCKED; // [RQ18]
              d.st[i].elapsed = '0;
            end else if (el_next >= exp_next) begin
              d.st[i].state = EFS_TRIP;
              d.st[i].elapsed = el_next;
            end else begin
              d.st[i].elapsed = el_next;
            end
          end
          EFS_TRIP: begin
            if (!pu_next) begin
              d.st[i].state = EFS_NORMAL;
              d.st[i].elapsed = '0;
            end
          end
          EFS_BLOCKED: begin
            if (!pu_next) begin
              d.st[i].state = EFS_NORMAL;
            end
          end
          default: d.st[i].state = EFS_NORMAL;
        endcase
      end

      // remaining time is zero outside timing, never negative
      if (d.st[i].state == EFS_START && d.st[i].exp_time > d.st[i].elapsed) begin
        d.st[i].remain = d.st[i].exp_time - d.st[i].elapsed; // [RQ15]
      end else begin
        d.st[i].remain = '0;
      end

      // force follows the setting immediately, only under the global enable
      d.st[i].cond = d.force_en ? d.st[i].force_to : d.st[i].state; // [RQ10] [RQ11]

      if (stage_hit) begin
        // unused bits and unmapped offsets read as zero
        case (off)
          `EFS_OFF_CFG: rd_val = {24'h00_0000, q.st[i].inverse, q.st[i].remote_ok, q.st[i].force_to,
                                  q.st[i].magt, q.st[i].sel};
          `EFS_OFF_REMOTE_THR: rd_val = 32'(q.st[i].thr[active_group]);
          `EFS_OFF_STATUS: rd_val = {25'h000_0000, q.st[i].fault, 2'h0, q.st[i].cond}; // [RQ11]
          `EFS_OFF_ANGLE: rd_val = 32'(signed'(q.st[i].angle)); // [RQ12]
          `EFS_OFF_EXPECT: rd_val = 32'(q.st[i].exp_time);
          `EFS_OFF_REMAIN: rd_val = 32'(q.st[i].remain); // [RQ15]
          `EFS_OFF_RATIO: rd_val = 32'(q.st[i].ratio); // [RQ16]
          `EFS_OFF_MAG: rd_val = 32'(q.st[i].mag);
          default: begin
            if (off[6:5] == `EFS_OFF_THR_HI && off[1:0] == 2'h0) begin
              rd_val = 32'(q.st[i].thr[off[4:2]]);
            end else if (off[6:5] == `EFS_OFF_DLY_HI && off[1:0] == 2'h0) begin
              rd_val = 32'(q.st[i].dly[off[4:2]]);
            end else begin
              rd_val = '0;
            end
          end
        endcase
      end
    end

    if (reg_addr == `EFS_ADDR_GCTL) begin
      rd_val = {31'h0000_0000, q.force_en};
    end
    // data stand for exactly one cycle after the read strobe
    d.rdata = reg_rd ? rd_val : '0;

    if (!ce) begin
      d = q;
    end
    // reset beats ce so a frozen block can still be cleared
    if (sys_rst) begin
      d = '0;
      for (int i = 0; i < `EFS_STAGES; i++) begin
        for (int g = 0; g < `EFS_GROUPS; g++) begin
          d.st[i].thr[g] = `EFS_THR_DEF; // [RQ7]
          d.st[i].dly[g] = `EFS_DLY_DEF;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign reg_rdata = q.rdata;

  // outputs decode the registered condition, so they only move on clock edges
  generate
    for (genvar i = 0; i < `EFS_STAGES; i++) begin : g_out
      assign stage_start[i] = q.st[i].cond == EFS_START; // [RQ20]
      assign stage_trip[i] = q.st[i].cond == EFS_TRIP;
      assign stage_blocked[i] = q.st[i].cond == EFS_BLOCKED;
    end
  endgenerate

endmodule : efs_top

`default_nettype wire

// ===== testbench/efs_meas_model.sv
// Purpose: residual current channels feeding the stage
// Assumes: one level is routed to the chosen channel
// Notes: other channels carry half the level, so a wrong source never picks up
`default_nettype none
`include "efs_cfg.svh"

module efs_meas_model
  import efs_pkg::*;
(
  // clock
  input wire logic clk,
  // stimulus
  input wire logic [2:0] chan,
  input wire logic [`EFS_MEAS_W-1:0] level,
  // channels in the port order of the stage
  output logic [6:0][`EFS_MEAS_W-1:0] meas
);
  always_ff @(posedge clk) begin
    for (int i = 0; i < 7; i++) begin
      meas[i] <= (3'(i) == chan) ? level : level >> 1;
    end
  end
endmodule : efs_meas_model

`default_nettype wire

// ===== testbench/efs_checker.sv
// Purpose: port-level checks of stage 0 of the earth fault stage
// Assumes: no register access while ce is low
// Notes: force state is tracked from register writes
`default_nettype none
`include "efs_cfg.svh"

module efs_checker
  import efs_pkg::*;
#(
  parameter int TICK_CYCLES = `EFS_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [`EFS_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // blocking and outputs
  input wire logic [`EFS_STAGES-1:0] block_in,
  input wire logic [`EFS_STAGES-1:0] stage_start,
  input wire logic [`EFS_STAGES-1:0] stage_trip,
  input wire logic [`EFS_STAGES-1:0] stage_blocked
);
  typedef struct packed {
    logic frc_on;
    logic [1:0] frc;
    logic [1:0] settle;
    logic [31:0] gap;
    logic [2:0] prev;
  } efs_chk_s;
  efs_chk_s chk_q;
  efs_chk_s chk_d;
  wire logic [2:0] outs = {stage_blocked[0], stage_trip[0], stage_start[0]};
  wire logic cfg_wr = reg_wr && (reg_addr == `EFS_ADDR_GCTL || reg_addr == 10'h000);

  // gap is preset to a large value after force edits, since those move outputs off the tick grid
  always_comb begin
    chk_d = chk_q;
    chk_d.prev = outs;
    if (reg_wr && reg_addr == `EFS_ADDR_GCTL) chk_d.frc_on = reg_wdata[0];
    if (reg_wr && reg_addr == 10'h000) chk_d.frc = reg_wdata[5:4];
    if (cfg_wr) chk_d.settle = 2'h0;
    else if (chk_q.settle != 2'h3) chk_d.settle = chk_q.settle + 2'h1;
    if (chk_q.settle < 2'h2) chk_d.gap = 32'h00FF_FFFF;
    else if (outs != chk_q.prev) chk_d.gap = 32'h0000_0000;
    else chk_d.gap = chk_q.gap + 32'h0000_0001;
    if (sys_rst) chk_d = '0;
  end

  always_ff @(posedge clk) chk_q <= chk_d;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_rst_idle; $past(sys_rst) |-> outs == 3'h0 && reg_rdata == 32'h0000_0000; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
  property p_onehot; $onehot0(outs); endproperty
  a_onehot: assert property (p_onehot) else $error("more than one condition shown");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_gctl_rd;
    $past(reg_rd) && $past(reg_addr) == `EFS_ADDR_GCTL |-> reg_rdata == {31'h0, $past(chk_q.frc_on)};
  endproperty
  a_gctl_rd: assert property (p_gctl_rd) else $error("forcing enable read wrong");
  property p_force;
    chk_q.settle >= 2'h2 && chk_q.frc_on |-> outs == 3'((4'h1 << chk_q.frc) >> 1);
  endproperty
  a_force: assert property (p_force) else $error("forced condition not shown");
  property p_trip;
    chk_q.settle >= 2'h2 && !chk_q.frc_on && $rose(stage_trip[0]) |-> $past(stage_start[0]);
  endproperty
  a_trip: assert property (p_trip) else $error("trip without start");
  property p_blk;
    chk_q.settle >= 2'h2 && !chk_q.frc_on && $rose(stage_blocked[0]) |-> $past(block_in[0], 3);
  endproperty
  a_blk: assert property (p_blk) else $error("blocked without block input");
  property p_gap;
    chk_q.settle >= 2'h2 && !chk_q.frc_on && outs != chk_q.prev |-> chk_q.gap >= TICK_CYCLES - 1;
  endproperty
  a_gap: assert property (p_gap) else $error("condition changed between ticks");
endmodule : efs_checker

bind efs_top efs_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .block_in(block_in), .stage_start(stage_start),
  .stage_trip(stage_trip), .stage_blocked(stage_blocked)
);

`default_nettype wire

// ===== testbench/tb_earth_fault_pickup_stage.sv
// Purpose: self-checking bench of the earth fault pick-up stage
// Assumes: tick shortened to 8 cycles, stage 0 exercised
// Notes: all waits bounded; a timeout ends the run
`default_nettype none
`include "efs_cfg.svh"

module tb_earth_fault_pickup_stage
  import efs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 8;
  localparam logic [7:0] CFG_TAB [7] = '{8'h00, 8'h04, 8'h08, 8'h01, 8'h05, 8'h09, 8'h06};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [`EFS_ADDR_W-1:0] reg_addr = 10'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic [6:0][`EFS_MEAS_W-1:0] meas;
  logic [2:0] chan = 3'h0;
  logic [`EFS_MEAS_W-1:0] level = 20'h0_0000;
  logic signed [`EFS_ANG_W-1:0] res_ang = 17'h0_03E8;
  logic signed [`EFS_ANG_W-1:0] u1_ang = 17'h0_012C;
  logic signed [`EFS_ANG_W-1:0] i1_ang = 17'h1_FF38;
  logic pvp = 1'b1;
  logic [1:0] fphase = 2'h0;
  logic frev = 1'b0;
  logic [2:0] grp = 3'h0;
  logic [3:0] blk = 4'h0;
  logic [3:0] st;
  logic [3:0] tr;
  logic [3:0] bl;
  logic [2:0] seen = 3'h0;
  int failures = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  efs_meas_model model (.clk(clk), .chan(chan), .level(level), .meas(meas));

  efs_top #(.TICK_CYCLES(T)) dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .coarse_rms(meas[0]), .coarse_trms(meas[1]), .coarse_pp(meas[2]), .sensitive_rms(meas[3]),
    .sensitive_trms(meas[4]), .sensitive_pp(meas[5]), .calculated_residual(meas[6]),
    .residual_angle(res_ang), .pos_seq_voltage_angle(u1_ang), .pos_seq_current_angle(i1_ang),
    .phase_voltages_present(pvp), .fault_phase(fphase), .fault_reverse(frev),
    .active_group(grp), .block_in(blk), .stage_start(st), .stage_trip(tr), .stage_blocked(bl)
  );

  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rdc(input logic [9:0] a, input logic [31:0] e, input string n);
    logic [31:0] v;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
    @(posedge clk);
    chk(n, e, v);
  endtask : rdc

  // outputs read mid-cycle; returns on a rising edge so the next stimulus lands there
  task automatic ticks(input int n);
    repeat (n * T - 1) @(posedge clk);
    @(negedge clk);
    seen = {bl[0], tr[0], st[0]};
    @(posedge clk);
  endtask : ticks

  task automatic wait_out(input logic [2:0] e, input string n);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clk);
      seen = {bl[0], tr[0], st[0]};
      if (seen === e) break;
    end
    @(posedge clk);
    chk(n, e, seen);
    if (i == 400) begin
      final_report();
    end
  endtask : wait_out

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc(10'h000, 32'h0000_0000, "cfg");
    rdc(10'h040, 32'h0000_2EE0, "thr");
    rdc(10'h060, 32'h0000_0014, "dly");
    rdc(`EFS_ADDR_GCTL, 32'h0000_0000, "gctl");
    rdc(10'h300, 32'h0000_0000, "unmapped");
    $display("test reset done");
    wr(10'h040, 32'h0000_0100);
    wr(10'h060, 32'h0000_0002);
    for (int k = 0; k < 7; k++) begin
      wr(10'h000, 32'(CFG_TAB[k]));
      chan <= 3'(k);
      level <= 20'h0_0200;
      wait_out(3'b001, "start");
      rdc(10'h01C, 32'h0000_0200, "mag");
      wait_out(3'b010, "trip");
      level <= 20'h0_0000;
      wait_out(3'b000, "normal");
    end
    $display("test sources done");
    wr(10'h040, 32'h0000_03E8);
    wr(10'h060, 32'h0000_0014);
    wr(10'h000, 32'h0000_0000);
    chan <= 3'h0;
    fphase <= 2'h1;
    frev <= 1'b1;
    level <= 20'h0_03E8;
    ticks(4);
    chk("at_thr", 32'h0000_0000, seen);
    level <= 20'h0_07D0;
    wait_out(3'b001, "start");
    rdc(10'h018, 32'h0000_00C8, "ratio");
    rdc(10'h008, 32'h0000_0041, "status");
    rdc(10'h010, 32'h0000_0014, "expect");
    level <= 20'h0_03CA;
    ticks(2);
    chk("held", 32'h0000_0001, seen);
    level <= 20'h0_03C9;
    wait_out(3'b000, "release");
    rdc(10'h00C, 32'h0000_02BC, "ang_u1");
    pvp <= 1'b0;
    ticks(2);
    rdc(10'h00C, 32'h0000_04B0, "ang_i1");
    $display("test pickup done");
    // block raised well ahead of any delay expiry
    blk <= 4'h1;
    ticks(1);
    level <= 20'h0_07D0;
    wait_out(3'b100, "blocked");
    level <= 20'h0_0000;
    wait_out(3'b000, "unblocked");
    blk <= 4'h0;
    wr(`EFS_ADDR_GCTL, 32'h0000_0001);
    rdc(`EFS_ADDR_GCTL, 32'h0000_0001, "gctl_on");
    for (int f = 0; f < 4; f++) begin
      wr(10'h000, 32'(f) << 4);
      wait_out(3'((4'h1 << f) >> 1), "forced");
      rdc(10'h008, 32'h0000_0040 | 32'(f), "status");
    end
    wr(`EFS_ADDR_GCTL, 32'h0000_0000);
    wr(10'h000, 32'h0000_0000);
    wait_out(3'b000, "unforced");
    $display("test force done");
    rdc(10'h004, 32'h0000_03E8, "remote_rd");
    wr(10'h004, 32'h0000_0555);
    rdc(10'h040, 32'h0000_03E8, "denied");
    wr(10'h000, 32'h0000_0040);
    wr(10'h004, 32'h0000_0555);
    rdc(10'h040, 32'h0000_0555, "allowed");
    wr(10'h044, 32'h0000_03E8);
    wr(10'h000, 32'h0000_00C0);
    grp <= 3'h1;
    rdc(10'h004, 32'h0000_03E8, "group1");
    wr(10'h000, 32'h0000_00CF);
    rdc(10'h000, 32'h0000_00C0, "cfg_kept");
    wr(10'h0C4, 32'h0000_03E8);
    level <= 20'h0_07D0;
    wait_out(3'b001, "inv_start");
    chk("stage1", 32'h0000_0001, 32'(st[1]));
    ticks(1);
    rdc(10'h010, 32'h0000_000A, "inv_exp");
    level <= 20'h0_0FA0;
    ticks(2);
    rdc(10'h010, 32'h0000_0005, "inv_exp2");
    level <= 20'h0_0000;
    wait_out(3'b000, "end");
    // ce low stops the time base, so no pick-up may appear
    ce <= 1'b0;
    level <= 20'h0_07D0;
    ticks(3);
    chk("frozen", 32'h0000_0000, seen);
    ce <= 1'b1;
    wait_out(3'b001, "resumed");
    level <= 20'h0_0000;
    wait_out(3'b000, "released");
    $display("test settings done");
    final_report();
  end
endmodule : tb_earth_fault_pickup_stage

`default_nettype wire
